// file: dv/tdc_dialer_bench.sv
// Testbench for the telephone dialer control over APB
`timescale 1ns/1ps
`default_nettype none
module tdc_dialer_bench;
  localparam logic [15:0] IX [14] = '{tdc_pkg::IDX_CLK, tdc_pkg::IDX_MODE, tdc_pkg::IDX_PAUSE,
    tdc_pkg::IDX_FLASH, tdc_pkg::IDX_PSEL, tdc_pkg::IDX_LINE, tdc_pkg::IDX_IDP, tdc_pkg::IDX_TONE,
    tdc_pkg::IDX_CODE, tdc_pkg::IDX_HOOK, tdc_pkg::IDX_TRI, tdc_pkg::IDX_PORT, tdc_pkg::IDX_IEN,
    tdc_pkg::IDX_IFLG};
  localparam logic [3:0] RV [14] = '{4'h0, 4'h0, 4'h4, 4'h6, 4'h0, 4'h0, 4'h8, 4'h3, 4'h0, 4'h3,
    4'h0, 4'hf, 4'h0, 4'h0};
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, slowOscIn = 0, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic        pready, pslverr, dialPulseOut, toneActive, rowToneEnable, columnToneEnable;
  logic        continuousTone, hookSwitchControl, fastOscillatorEnable, cpuClockSwitch, dialerIrq;
  logic [3:0]  toneCode, portPinOut, portPinOe_n, pinLevel;
  int          errTotal = 0, nChecks = 0, pulseCount, breakLen, i;
  always #2.5 clk = ~clk;
  // Fast slow-oscillator ticks keep the run short
  always @(posedge clk) slowOscIn <= ~slowOscIn;
  tdc_dialer dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slowOscIn(slowOscIn), .dialPulseOut(dialPulseOut), .toneActive(toneActive),
    .toneCode(toneCode), .rowToneEnable(rowToneEnable), .columnToneEnable(columnToneEnable),
    .continuousTone(continuousTone), .hookSwitchControl(hookSwitchControl),
    .fastOscillatorEnable(fastOscillatorEnable), .cpuClockSwitch(cpuClockSwitch),
    .portPinOut(portPinOut), .portPinOe_n(portPinOe_n), .dialerIrq(dialerIrq));
  tdc_line_model line (.clk(clk), .srst(srst), .dialPulseOut(dialPulseOut),
    .portPinOut(portPinOut), .portPinOe_n(portPinOe_n), .pinLevel(pinLevel),
    .pulseCount(pulseCount), .breakLen(breakLen));
  task automatic testDone;
    if (errTotal == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : testDone
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errTotal++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Idle cycle after each transfer avoids two drives in one step
  task automatic apb(input logic w, input logic [15:0] ix, input logic [3:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {14'h0000, ix, 2'b00}; pwdata <= {28'h0, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [15:0] ix, input logic [3:0] e);
    apb(0, ix, 4'h0);
    chk($sformatf("reg %h", ix), {28'h0, e}, rd);
  endtask : rchk
  initial begin
    #(300_000);
    errTotal++;
    testDone();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    for (i = 0; i < 14; i++) rchk(IX[i], RV[i]);
    chk("outs", 7'h06, {cpuClockSwitch, fastOscillatorEnable, hookSwitchControl, continuousTone,
      rowToneEnable, columnToneEnable, toneActive});
    apb(1, tdc_pkg::IDX_CLK, 4'hc);
    chk("clk", 2'h3, {cpuClockSwitch, fastOscillatorEnable});
    apb(1, 16'h0001, 4'hf);
    chk("slverr", 1, er);
    apb(1, tdc_pkg::IDX_PORT, 4'h5);
    chk("port", 4'h5, pinLevel);
    apb(1, tdc_pkg::IDX_TRI, 4'h2);
    chk("hiz", 4'h2, portPinOe_n);
    apb(1, tdc_pkg::IDX_TRI, 4'h0);
    apb(1, tdc_pkg::IDX_PORT, 4'hf);
    apb(1, tdc_pkg::IDX_PSEL, 4'hf);
    apb(1, tdc_pkg::IDX_LINE, 4'hc);
    chk("special", 4'he, pinLevel);
    apb(1, tdc_pkg::IDX_LINE, 4'h0);
    chk("special", 4'h3, pinLevel);
    apb(1, tdc_pkg::IDX_MODE, 4'hb);
    apb(1, tdc_pkg::IDX_IDP, 4'h1);
    apb(1, tdc_pkg::IDX_IEN, 4'h1);
    apb(1, tdc_pkg::IDX_CODE, 4'h3);
    chk("mute", 4'h0, pinLevel);
    apb(1, tdc_pkg::IDX_CODE, 4'h5);
    for (i = 0; i < 40000 && dialerIrq !== 1'b1; i++) @(posedge clk);
    chk("irq", 1, dialerIrq);
    chk("pulses", 3, pulseCount);
    chk("break", 1, breakLen inside {[2180:2190]});
    chk("mhold", 4'h0, pinLevel);
    repeat (300) @(posedge clk);
    chk("mhold", 4'h3, pinLevel);
    apb(1, tdc_pkg::IDX_IEN, 4'h0);
    chk("irq", 0, dialerIrq);
    rchk(tdc_pkg::IDX_IFLG, 4'h1);
    apb(1, tdc_pkg::IDX_IFLG, 4'h1);
    rchk(tdc_pkg::IDX_IFLG, 4'h0);
    chk("code", 4'h3, toneCode);
    apb(1, tdc_pkg::IDX_MODE, 4'h0);
    apb(1, tdc_pkg::IDX_CODE, 4'h7);
    chk("tone", 2'h3, {toneActive, dialPulseOut});
    chk("code", 4'h7, toneCode);
    testDone();
  end
endmodule : tdc_dialer_bench
`default_nettype wire

// file: dv/tdc_line_model.sv
// Line side model: pin levels, dial pulse count, break length
`timescale 1ns/1ps
`default_nettype none
module tdc_line_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Device pins
  input  wire logic       dialPulseOut,
  input  wire logic [3:0] portPinOut,
  input  wire logic [3:0] portPinOe_n,
  // Observed line
  output logic      [3:0] pinLevel,
  output int              pulseCount,
  output int              breakLen
);
  logic [3:0] lastOut_ff;
  logic       dpPrev_ff;
  int         lowRun_ff;
  // No pull on these lines, so a floating pin shows the inverse
  always_ff @(posedge clk) lastOut_ff <= (portPinOut & ~portPinOe_n) | (lastOut_ff & portPinOe_n);
  assign pinLevel = (portPinOut & ~portPinOe_n) | (~lastOut_ff & portPinOe_n);
  // Make comes first, so each break start is one pulse
  always_ff @(posedge clk) begin
    dpPrev_ff <= dialPulseOut;
    lowRun_ff <= dialPulseOut ? 0 : lowRun_ff + 1;
    if (srst) begin
      pulseCount <= 0;
      breakLen   <= 0;
    end else begin
      if (dpPrev_ff && !dialPulseOut) pulseCount <= pulseCount + 1;
      if (!dpPrev_ff && dialPulseOut) breakLen <= lowRun_ff;
    end
  end
endmodule : tdc_line_model
`default_nettype wire

// file: rtl/tdc_dialer.sv
// Telephone dialer control: APB registers, dial sequencer and port pins
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tdc_dialer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Slow oscillator level
  input  wire logic        slowOscIn,
  // Line and tone side
  output logic             dialPulseOut,
  output logic             toneActive,
  output logic      [3:0]  toneCode,
  output logic             rowToneEnable,
  output logic             columnToneEnable,
  output logic             continuousTone,
  output logic             hookSwitchControl,
  // Clock control
  output logic             fastOscillatorEnable,
  output logic             cpuClockSwitch,
  // Port pins, enable low while driven
  output logic      [3:0]  portPinOut,
  output logic      [3:0]  portPinOe_n,
  // Interrupt request
  output logic             dialerIrq
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [3:0]          clkCtl_ff;
  logic [3:0]          modeCfg_ff;
  logic [3:0]          pauseDur_ff;
  logic [3:0]          flashDur_ff;
  logic [3:0]          pinSel_ff;
  logic [1:0]          lineCtl_ff;
  logic [3:0]          idpDur_ff;
  logic [3:0]          toneCtl_ff;
  logic [3:0]          dialCode_ff;
  logic [3:0]          hookMute_ff;
  logic [3:0]          triState_ff;
  logic [3:0]          portData_ff;
  logic                irqEn_ff;
  logic                irqFlag_ff;
  logic [31:0]         prdata_ff;
  logic                slowPrev_ff;
  logic [tdc_pkg::TW-1:0] cnt_ff;
  logic [tdc_pkg::TW-1:0] nxt_cnt;
  logic [3:0]          pulses_ff;
  logic [3:0]          nxt_pulses;
  tdc_pkg::tdc_state_e state_ff;
  tdc_pkg::tdc_state_e nxt_state;

  logic        wrEn;
  logic        addrOk;
  logic [15:0] idx;
  logic        tick;
  logic        busy;
  logic        codeAcc;
  logic        pauseGo;
  logic        flashGo;
  logic        irqEvent;
  logic        muteAct;
  logic        txMute;
  logic        rxMute;
  logic [3:0]  special;
  logic [tdc_pkg::TW-1:0] makeT;
  logic [tdc_pkg::TW-1:0] brkT;

  function automatic logic mapped(input logic [15:0] i);
    mapped = (i == tdc_pkg::IDX_CLK)   || (i == tdc_pkg::IDX_MODE)  ||
             (i == tdc_pkg::IDX_PAUSE) || (i == tdc_pkg::IDX_FLASH) ||
             (i == tdc_pkg::IDX_PSEL)  || (i == tdc_pkg::IDX_LINE)  ||
             (i == tdc_pkg::IDX_IDP)   || (i == tdc_pkg::IDX_TONE)  ||
             (i == tdc_pkg::IDX_CODE)  || (i == tdc_pkg::IDX_HOOK)  ||
             (i == tdc_pkg::IDX_TRI)   || (i == tdc_pkg::IDX_PORT)  ||
             (i == tdc_pkg::IDX_IEN)   || (i == tdc_pkg::IDX_IFLG);
  endfunction : mapped

  // Step codes share one mapping for flash and inter-digit gap
  function automatic logic [tdc_pkg::TW-1:0] steps(input logic [3:0] c);
    steps = tdc_pkg::TW'(c * tdc_pkg::STEP_T);
  endfunction : steps

  // ************************************************************
  // APB access
  // ************************************************************
  assign idx     = paddr[17:2];
  assign addrOk  = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0) && mapped(idx);
  assign wrEn    = psel && penable && pwrite && addrOk;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign prdata  = prdata_ff;

  // Read data captured in setup so it leaves a flop in the access phase
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      unique case (idx)
        tdc_pkg::IDX_CLK:   prdata_ff[3:0] <= clkCtl_ff;
        tdc_pkg::IDX_MODE:  prdata_ff[3:0] <= modeCfg_ff;
        tdc_pkg::IDX_PAUSE: prdata_ff[3:0] <= pauseDur_ff;
        tdc_pkg::IDX_FLASH: prdata_ff[3:0] <= flashDur_ff;
        tdc_pkg::IDX_PSEL:  prdata_ff[3:0] <= pinSel_ff;
        tdc_pkg::IDX_LINE:  prdata_ff[3:0] <= {lineCtl_ff, 2'b00};
        tdc_pkg::IDX_IDP:   prdata_ff[3:0] <= idpDur_ff;
        tdc_pkg::IDX_TONE:  prdata_ff[3:0] <= toneCtl_ff;
        tdc_pkg::IDX_CODE:  prdata_ff[3:0] <= dialCode_ff;
        tdc_pkg::IDX_HOOK:  prdata_ff[3:0] <= hookMute_ff;
        tdc_pkg::IDX_TRI:   prdata_ff[3:0] <= triState_ff;
        tdc_pkg::IDX_PORT:  prdata_ff[3:0] <= portData_ff;
        tdc_pkg::IDX_IEN:   prdata_ff[0]   <= irqEn_ff;
        tdc_pkg::IDX_IFLG:  prdata_ff[0]   <= irqFlag_ff;
        default:            prdata_ff      <= 32'h0000_0000;
      endcase
    end
  end

  // Unused bits are masked so they always read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      clkCtl_ff   <= 4'h0;
      modeCfg_ff  <= 4'h0;
      pauseDur_ff <= tdc_pkg::RST_PAUSE;
      flashDur_ff <= tdc_pkg::RST_FLASH;
      pinSel_ff   <= 4'h0;
      lineCtl_ff  <= 2'h0;
      idpDur_ff   <= tdc_pkg::RST_IDP;
      toneCtl_ff  <= {2'b00, tdc_pkg::RST_SIN};
      hookMute_ff <= {2'b00, tdc_pkg::RST_MUTE};
      triState_ff <= 4'h0;
      portData_ff <= tdc_pkg::RST_PORT;
      irqEn_ff    <= 1'b0;
    end else if (wrEn) begin
      unique case (idx)
        tdc_pkg::IDX_CLK:   clkCtl_ff   <= pwdata[3:0] & 4'hd;
        tdc_pkg::IDX_MODE:  modeCfg_ff  <= pwdata[3:0] & 4'hb;
        tdc_pkg::IDX_PAUSE: pauseDur_ff <= pwdata[3:0];
        tdc_pkg::IDX_FLASH: flashDur_ff <= pwdata[3:0];
        tdc_pkg::IDX_PSEL:  pinSel_ff   <= pwdata[3:0];
        tdc_pkg::IDX_LINE:  lineCtl_ff  <= pwdata[tdc_pkg::B_HF:tdc_pkg::B_HOLD];
        tdc_pkg::IDX_IDP:   idpDur_ff   <= pwdata[3:0];
        tdc_pkg::IDX_TONE:  toneCtl_ff  <= pwdata[3:0] & 4'hb;
        tdc_pkg::IDX_HOOK:  hookMute_ff <= pwdata[3:0] & 4'hb;
        tdc_pkg::IDX_TRI:   triState_ff <= pwdata[3:0];
        tdc_pkg::IDX_PORT:  portData_ff <= pwdata[3:0];
        tdc_pkg::IDX_IEN:   irqEn_ff    <= pwdata[tdc_pkg::B_IRQ];
        default:            irqEn_ff    <= irqEn_ff;
      endcase
    end
  end

  // Code held only when the sequencer takes it
  always_ff @(posedge clk) begin
    if (srst) begin
      dialCode_ff <= 4'h0;
    end else if (codeAcc) begin
      dialCode_ff <= pwdata[3:0];
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irqFlag_ff <= 1'b0;
    end else if (irqEvent) begin
      irqFlag_ff <= 1'b1;
    end else if (wrEn && idx == tdc_pkg::IDX_IFLG && pwdata[tdc_pkg::B_IRQ]) begin
      irqFlag_ff <= 1'b0;
    end
  end

  assign dialerIrq = irqFlag_ff && irqEn_ff;

  // ************************************************************
  // Dial sequencer
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      slowPrev_ff <= 1'b0;
    end else begin
      slowPrev_ff <= slowOscIn;
    end
  end

  assign tick    = slowOscIn && !slowPrev_ff;
  assign busy    = !(state_ff == tdc_pkg::ST_IDLE || state_ff == tdc_pkg::ST_MHOLD);
  assign codeAcc = wrEn && idx == tdc_pkg::IDX_CODE && !busy;
  assign flashGo = wrEn && idx == tdc_pkg::IDX_LINE && pwdata[tdc_pkg::B_FLASH] && !busy;
  assign pauseGo = wrEn && idx == tdc_pkg::IDX_LINE && pwdata[tdc_pkg::B_PAUSE] && !busy;

  // Make and break lengths from rate and ratio
  always_comb begin
    unique case ({modeCfg_ff[tdc_pkg::B_DRS], modeCfg_ff[tdc_pkg::B_MB]})
      2'b00: begin makeT = tdc_pkg::MK10_40; brkT = tdc_pkg::BK10_40; end
      2'b01: begin makeT = tdc_pkg::MK10_33; brkT = tdc_pkg::BK10_33; end
      2'b10: begin makeT = tdc_pkg::MK20_40; brkT = tdc_pkg::BK20_40; end
      default: begin makeT = tdc_pkg::MK20_33; brkT = tdc_pkg::BK20_33; end
    endcase
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_pulses = pulses_ff;
    nxt_cnt    = (tick && cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
    irqEvent   = 1'b0;
    unique case (state_ff)
      tdc_pkg::ST_IDLE, tdc_pkg::ST_MHOLD: begin
        if (flashGo) begin
          nxt_state = tdc_pkg::ST_FLASH;
          nxt_cnt   = steps(flashDur_ff);
        end else if (pauseGo) begin
          nxt_state = tdc_pkg::ST_PAUSE;
          nxt_cnt   = tdc_pkg::TW'(pauseDur_ff * tdc_pkg::SEC_T);
        end else if (codeAcc && modeCfg_ff[tdc_pkg::B_TPS]) begin
          nxt_state  = tdc_pkg::ST_MAKE;
          nxt_pulses = pwdata[3:0];
          nxt_cnt    = makeT;
        end else if (codeAcc) begin
          nxt_state = tdc_pkg::ST_TONE;
          nxt_cnt   = tdc_pkg::STEP_T;
        end else if (state_ff == tdc_pkg::ST_MHOLD && cnt_ff == '0) begin
          nxt_state = tdc_pkg::ST_IDLE;
        end
      end
      tdc_pkg::ST_MAKE: begin
        if (cnt_ff == '0) begin
          nxt_state = tdc_pkg::ST_BRK;
          nxt_cnt   = brkT;
        end
      end
      tdc_pkg::ST_BRK: begin
        if (cnt_ff == '0 && pulses_ff <= 4'h1) begin
          nxt_state = tdc_pkg::ST_IDGAP;
          nxt_cnt   = steps(idpDur_ff);
        end else if (cnt_ff == '0) begin
          nxt_state  = tdc_pkg::ST_MAKE;
          nxt_pulses = pulses_ff - 4'h1;
          nxt_cnt    = makeT;
        end
      end
      tdc_pkg::ST_IDGAP, tdc_pkg::ST_TGAP: begin
        if (cnt_ff == '0) begin
          nxt_state = tdc_pkg::ST_MHOLD;
          nxt_cnt   = tdc_pkg::MHOLD_T;
          irqEvent  = 1'b1;
        end
      end
      tdc_pkg::ST_TONE: begin
        if (cnt_ff == '0 && !toneCtl_ff[tdc_pkg::B_CTO]) begin
          nxt_state = tdc_pkg::ST_TGAP;
          nxt_cnt   = tdc_pkg::STEP_T;
        end
      end
      tdc_pkg::ST_PAUSE: begin
        if (cnt_ff == '0) begin
          nxt_state = tdc_pkg::ST_IDLE;
          irqEvent  = 1'b1;
        end
      end
      tdc_pkg::ST_FLASH: begin
        if (cnt_ff == '0) begin
          nxt_state = tdc_pkg::ST_FLPS;
          nxt_cnt   = tdc_pkg::FLPS_T;
        end
      end
      tdc_pkg::ST_FLPS: begin
        if (cnt_ff == '0) begin
          nxt_state = tdc_pkg::ST_IDLE;
          irqEvent  = 1'b1;
        end
      end
      default: nxt_state = tdc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff  <= tdc_pkg::ST_IDLE;
      cnt_ff    <= '0;
      pulses_ff <= 4'h0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pulses_ff <= nxt_pulses;
    end
  end

  // ************************************************************
  // Line outputs and port pins
  // ************************************************************
  assign muteAct = !(state_ff == tdc_pkg::ST_IDLE || state_ff == tdc_pkg::ST_PAUSE ||
                     state_ff == tdc_pkg::ST_FLASH || state_ff == tdc_pkg::ST_FLPS);
  assign dialPulseOut = !(state_ff == tdc_pkg::ST_BRK || state_ff == tdc_pkg::ST_FLASH);
  assign txMute = !((hookMute_ff[tdc_pkg::B_TRANSMIT_MUTE_CONTROL] && muteAct) || lineCtl_ff[0] ||
                    state_ff == tdc_pkg::ST_FLASH);
  assign rxMute = !((hookMute_ff[tdc_pkg::B_RECEIVE_MUTE_CONTROL] && muteAct) ||
                    state_ff == tdc_pkg::ST_FLASH);
  assign special = {lineCtl_ff[1], lineCtl_ff[0], rxMute, txMute};

  assign toneActive           = state_ff == tdc_pkg::ST_TONE;
  assign toneCode             = dialCode_ff;
  assign rowToneEnable        = toneCtl_ff[tdc_pkg::B_ROW_TONE_ENABLE];
  assign columnToneEnable     = toneCtl_ff[tdc_pkg::B_COLUMN_TONE_ENABLE];
  assign continuousTone       = toneCtl_ff[tdc_pkg::B_CTO];
  assign hookSwitchControl    = hookMute_ff[tdc_pkg::B_HOOK_SWITCH_CONTROL];
  assign fastOscillatorEnable = clkCtl_ff[tdc_pkg::B_FOSC];
  assign cpuClockSwitch       = clkCtl_ff[tdc_pkg::B_CPUCLK];

  // Special signal is gated by its data bit, so data zero pins it low
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign portPinOut[i]  = pinSel_ff[i] ? (special[i] && portData_ff[i])
                                         : portData_ff[i];
    assign portPinOe_n[i] = triState_ff[i];
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_codePulse;
    codeAcc && modeCfg_ff[tdc_pkg::B_TPS] && !flashGo && !pauseGo;
  endsequence
  sequence s_makeEnd;
    state_ff == tdc_pkg::ST_MAKE && cnt_ff == '0;
  endsequence

  AST_PULSE_START: assert property (s_codePulse |=> dialPulseOut && !txMute == hookMute_ff[0])
    else $error("pulse digit did not start with make");
  AST_MAKE_THEN_BREAK: assert property (s_makeEnd |=> !dialPulseOut ##0 state_ff == tdc_pkg::ST_BRK)
    else $error("make not followed by break");
  AST_TONE_MODE: assert property (codeAcc && !modeCfg_ff[tdc_pkg::B_TPS] && !flashGo && !pauseGo
                                  |=> toneActive && dialPulseOut)
    else $error("tone mode write did not start tone");
  AST_BUSY_IGNORE: assert property (busy && wrEn && idx == tdc_pkg::IDX_CODE
                                    |=> $stable(dialCode_ff))
    else $error("dial code taken while busy");
  AST_FLAG_SET: assert property (irqEvent |=> irqFlag_ff)
    else $error("completion did not set flag");
  AST_IRQ_MASK: assert property ($rose(irqFlag_ff) && irqEn_ff |-> dialerIrq)
    else $error("enabled flag not passed to request");
  AST_FLASH_LOW: assert property (flashGo |=> (!dialPulseOut && !rxMute) [*2])
    else $error("flash did not hold line low");
  AST_PAUSE_READ0: assert property (psel && !penable && !pwrite && idx == tdc_pkg::IDX_LINE
                                    |=> prdata[tdc_pkg::B_PAUSE:tdc_pkg::B_FLASH] == 2'b00)
    else $error("trigger bits read nonzero");
  AST_TRI_WRITE: assert property (wrEn && idx == tdc_pkg::IDX_TRI |=> portPinOe_n == $past(pwdata[3:0]))
    else $error("tri-state write not applied");
  AST_MUTE_HOLD: assert property (state_ff == tdc_pkg::ST_MHOLD && hookMute_ff[tdc_pkg::B_RECEIVE_MUTE_CONTROL]
                                  |-> !rxMute)
    else $error("mute released during hold time");
  AST_PAUSE_DP: assert property (pauseGo |=> dialPulseOut && state_ff == tdc_pkg::ST_PAUSE)
    else $error("pause trigger did not start pause");

endmodule : tdc_dialer
`default_nettype wire

// file: shared/tdc_pkg.sv
// Constants, register map and state codes for the telephone dialer control
// How it works
// - Mode bit picks pulse dialing when one, tone when zero; resets zero.
// - Ratio bit gives 33.3:66.6 when one, 40:60 when zero; pulse only.
// - Each dial pulse is make (high) first, then break (low).
// - Rate bit gives 20 pps when one, 10 pps when zero; pulse only.
// - Pause code N gives N seconds; resets to 4; software never writes 0.
// - Pause runs only when the pause trigger bit is written with one.
// - Flash code N gives N times about 94 ms; resets to the 563 ms code.
// - Inter-digit gap uses the flash mapping; pulse only; resets to 750 ms.
// - Writing the dial code starts dialing; code N gives N pulses, code 0 gives one.
// - Mute outputs follow their mute control bits, which reset to one.
// - Pin select one routes the dialer signal, zero the port data bit; the code ANDs the dialer signal with the port data bit.
// - Tri-state bit one floats its pin, zero drives it; resets zero.
// - Port data bit drives its pin high or low; resets to one.
// - Hold and handsfree indications follow their control bits.
// - Interrupt enable passes the dialer request when one; resets zero.
// - Continuous tone bit keeps the tone on while set; resets zero.
// - Row and column tone enables reset to one for dual tone.
// - Pause trigger reads zero, interrupts at pause end, clears itself.
// - Flash trigger holds pulse and mutes low, then interrupts, clears.
// - Interrupt flag sets on each completion; software clears with one.
// - Mutes stay low 4 ms after the gap unless a new digit, pause or flash starts.
package tdc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] IDX_CLK   = 16'hff00;
  localparam logic [15:0] IDX_MODE  = 16'hff10;
  localparam logic [15:0] IDX_PAUSE = 16'hff11;
  localparam logic [15:0] IDX_FLASH = 16'hff12;
  localparam logic [15:0] IDX_PSEL  = 16'hff13;
  localparam logic [15:0] IDX_LINE  = 16'hff14;
  localparam logic [15:0] IDX_IDP   = 16'hff15;
  localparam logic [15:0] IDX_TONE  = 16'hff16;
  localparam logic [15:0] IDX_CODE  = 16'hff17;
  localparam logic [15:0] IDX_HOOK  = 16'hff18;
  localparam logic [15:0] IDX_TRI   = 16'hff32;
  localparam logic [15:0] IDX_PORT  = 16'hff33;
  localparam logic [15:0] IDX_IEN   = 16'hffe9;
  localparam logic [15:0] IDX_IFLG  = 16'hfff9;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int B_CPUCLK = 3;
  localparam int B_FOSC   = 2;
  localparam int B_GP     = 0;
  localparam int B_TPS    = 3;
  localparam int B_MB     = 1;
  localparam int B_DRS    = 0;
  localparam int B_HF     = 3;
  localparam int B_HOLD   = 2;
  localparam int B_PAUSE  = 1;
  localparam int B_FLASH  = 0;
  localparam int B_CTO    = 3;
  localparam int B_ROW_TONE_ENABLE   = 1;
  localparam int B_COLUMN_TONE_ENABLE   = 0;
  localparam int B_HOOK_SWITCH_CONTROL   = 3;
  localparam int B_RECEIVE_MUTE_CONTROL  = 1;
  localparam int B_TRANSMIT_MUTE_CONTROL  = 0;
  localparam int B_IRQ    = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] RST_PAUSE = 4'h4;
  localparam logic [3:0] RST_FLASH = 4'h6;
  localparam logic [3:0] RST_IDP   = 4'h8;
  localparam logic [3:0] RST_PORT  = 4'hf;
  localparam logic [1:0] RST_MUTE  = 2'h3;
  localparam logic [1:0] RST_SIN   = 2'h3;

  // ************************************************************
  // Timing, counted in slow oscillator ticks
  // ************************************************************
  localparam longint SLOW_HZ   = 64'h0000_0000_0000_8000;
  localparam longint STEP_US   = 64'h0000_0000_0001_6e36;
  localparam longint SEC_US    = 64'h0000_0000_000f_4240;
  localparam longint MHOLD_US  = 64'h0000_0000_0000_0fa0;
  localparam longint P10_US    = 64'h0000_0000_0001_86a0;
  localparam longint P20_US    = 64'h0000_0000_0000_c350;
  localparam longint M10_40_US = 64'h0000_0000_0000_9c40;
  localparam longint M10_33_US = 64'h0000_0000_0000_8235;
  localparam longint M20_40_US = 64'h0000_0000_0000_4e20;
  localparam longint M20_33_US = 64'h0000_0000_0000_411b;
  localparam longint FLPS_STEPS = 64'h0000_0000_0000_000a;
  localparam int     TW        = 20;
  localparam logic [TW-1:0] STEP_T  = TW'(STEP_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] SEC_T   = TW'(SLOW_HZ);
  localparam logic [TW-1:0] MHOLD_T = TW'(MHOLD_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] FLPS_T  = TW'(FLPS_STEPS * STEP_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] MK10_40 = TW'(M10_40_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] MK10_33 = TW'(M10_33_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] MK20_40 = TW'(M20_40_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] MK20_33 = TW'(M20_33_US * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] BK10_40 = TW'((P10_US - M10_40_US) * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] BK10_33 = TW'((P10_US - M10_33_US) * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] BK20_40 = TW'((P20_US - M20_40_US) * SLOW_HZ / SEC_US);
  localparam logic [TW-1:0] BK20_33 = TW'((P20_US - M20_33_US) * SLOW_HZ / SEC_US);

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [9:0] {
    ST_IDLE  = 10'b00_0000_0001,
    ST_MAKE  = 10'b00_0000_0010,
    ST_BRK   = 10'b00_0000_0100,
    ST_IDGAP = 10'b00_0000_1000,
    ST_MHOLD = 10'b00_0001_0000,
    ST_TONE  = 10'b00_0010_0000,
    ST_TGAP  = 10'b00_0100_0000,
    ST_PAUSE = 10'b00_1000_0000,
    ST_FLASH = 10'b01_0000_0000,
    ST_FLPS  = 10'b10_0000_0000
  } tdc_state_e;

endpackage : tdc_pkg
